// ===== rtl/hps_pkg.sv
// package: constants and types for the host interface protocol selector
`default_nettype none
package hps_pkg;
  // edge count needed during a chip-select low phase to enter spi
  localparam int unsigned SPI_EDGE_MIN   = 16;
  localparam int unsigned EDGE_CNT_W     = 5;
  localparam logic [4:0]  EDGE_CNT_RESET = 5'h00;
  // i3c broadcast address and address shift width
  localparam logic [6:0]  I3C_BCAST_ADDR = 7'h7E;
  localparam logic [7:0]  SHIFT_RESET    = 8'h00;
  localparam logic [3:0]  BIT_CNT_RESET  = 4'h0;
  localparam logic [3:0]  ADDR_BITS      = 4'h8;

  // interface protocol states
  typedef enum logic [1:0] {
    HPS_I2C,
    HPS_I3C,
    HPS_SPI
  } hps_mode_e;

  // synchronised bus pins
  typedef struct packed {
    logic csbN;
    logic sck;
    logic sda;
  } hps_pins_s;

  // mode flags towards the protocol engines
  typedef struct packed {
    logic i2cEn;
    logic i3cEn;
    logic spiEn;
    logic spiCpol;
  } hps_sel_s;

  // idle levels of the bus lines and the flags after reset
  localparam hps_pins_s PIN_IDLE  = '{csbN: 1'b1, sck: 1'b1, sda: 1'b1};
  localparam hps_sel_s  SEL_RESET = '{i2cEn: 1'b1, i3cEn: 1'b0, spiEn: 1'b0, spiCpol: 1'b0};
endpackage
`default_nettype wire

// ===== rtl/hps_sync.sv
// two-flop synchroniser for the bus pins
`default_nettype none
module hps_sync (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              resetn,
  // raw and synchronised pins
  input  wire hps_pkg::hps_pins_s pinIn,
  output var  hps_pkg::hps_pins_s pinOut
);
  import hps_pkg::*;
  hps_pins_s stage1;
  // csb idles high so the flops reset to the idle level
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= PIN_IDLE;
      pinOut <= PIN_IDLE;
    end else begin
      stage1 <= pinIn;
      pinOut <= stage1;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/hps_select.sv
// host interface protocol selector: i2c, i3c or spi
`default_nettype none
// Operation
// - the single host interface is slave only, running spi, i3c or i2c
// - power-up or soft reset starts in combined i2c/i3c state
// - chip select low disables i2c/i3c at once
// - spi entered when csb rises after low phase with at least 16 edges
// - broadcast address 7E seen in i2c locks interface into i3c
// - leaving spi only by power-down or soft reset; i3c is also left for spi on a csb rise after at least 16 edges
// - i2c supports standard, fast and fast-plus speeds
// - i3c supports single data rate transfers only
// - spi modes 00 and 11, picked from sck level after csb falls
module hps_select (
  // clock and reset
  input  wire logic  mclk,
  input  wire logic  resetn,
  input  wire logic  softReset,
  // bus pins
  input  wire logic  csbN,
  input  wire logic  sck,
  input  wire logic  sda,
  // selection outputs
  output var  hps_pkg::hps_sel_s sel,
  output var  hps_pkg::hps_mode_e mode,
  output logic       csbActive
);
  import hps_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  hps_pins_s pinsRaw;
  hps_pins_s pins;
  hps_pins_s pinsDly;
  // pack the raw pins first so the port sees a plain struct
  assign pinsRaw = '{csbN: csbN, sck: sck, sda: sda};
  hps_sync u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pinIn  (pinsRaw),
    .pinOut (pins)
  );

  // one-cycle delayed copy for edge detection
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pinsDly <= PIN_IDLE;
    end else begin
      pinsDly <= pins;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge decoding shared by the chip-select and serial line detectors
  function automatic logic risen(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  function automatic logic fallen(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  // a line high in both samples, as start and stop need for scl
  function automatic logic heldHigh(input logic prev, input logic cur);
    return prev & cur;
  endfunction

  logic csbFall;
  logic csbRise;
  logic sckEdge;
  logic sckRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  assign csbFall   = fallen(pinsDly.csbN, pins.csbN);
  assign csbRise   = risen(pinsDly.csbN, pins.csbN);
  assign sckEdge   = pinsDly.sck ^ pins.sck;
  assign sckRise   = risen(pinsDly.sck, pins.sck);
  assign sclFall   = fallen(pinsDly.sck, pins.sck);
  // start and stop: sda moves while scl high
  assign startCond = fallen(pinsDly.sda, pins.sda) & heldHigh(pinsDly.sck, pins.sck);
  assign stopCond  = risen(pinsDly.sda, pins.sda) & heldHigh(pinsDly.sck, pins.sck);
  // synchronised level; the registered flags follow one cycle later
  assign csbActive = ~pins.csbN;

  ////////////////////////////////////////////////////////////////////////
  // sck edge counter during chip-select low phase
  // both sck polarities count, so sixteen edges are eight full clocks;
  // an edge in the very cycle of the csb fall is not counted
  logic [EDGE_CNT_W-1:0] edgeCnt;
  logic                  edgesMet;
  assign edgesMet = (edgeCnt >= EDGE_CNT_W'(SPI_EDGE_MIN));
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      edgeCnt <= EDGE_CNT_RESET;
    end else if (csbFall) begin
      edgeCnt <= EDGE_CNT_RESET;
    end else if (!pins.csbN && sckEdge && !edgesMet) begin
      edgeCnt <= edgeCnt + 5'h01;
    end
  end
  // saturating at the threshold keeps the counter narrow

  ////////////////////////////////////////////////////////////////////////
  // spi clock polarity captured on the cycle after csb falls
  // taken at every csb fall in any mode, so it is already right when
  // the frame that switches the interface to spi ends
  logic spiCpol;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      spiCpol <= 1'b0;
    end else if (csbFall) begin
      spiCpol <= pins.sck;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // i2c address byte watcher for the i3c broadcast address
  // the watcher runs in every mode but only the i2c state acts on it,
  // so a broadcast seen after a switch to spi changes nothing
  logic [7:0] addrShift;
  logic [3:0] bitCnt;
  logic       addrPhase;
  logic       watchClear;
  logic       lastAddrBit;
  // stop or soft reset abandons a frame; start opens a fresh address byte
  assign watchClear  = softReset | stopCond | startCond;
  assign lastAddrBit = (bitCnt == ADDR_BITS - 4'h1);

  // address bits, msb first on scl rises
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addrShift <= SHIFT_RESET;
    end else if (watchClear) begin
      addrShift <= SHIFT_RESET;
    end else if (addrPhase && sckRise) begin
      addrShift <= {addrShift[6:0], pins.sda};
    end
  end

  // bits taken so far; parks at eight until the next start or stop
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bitCnt <= BIT_CNT_RESET;
    end else if (watchClear) begin
      bitCnt <= BIT_CNT_RESET;
    end else if (addrPhase && sckRise) begin
      bitCnt <= bitCnt + 4'h1;
    end
  end

  // open from start until the eighth address bit
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addrPhase <= 1'b0;
    end else if (softReset || stopCond) begin
      addrPhase <= 1'b0;
    end else if (startCond) begin
      addrPhase <= 1'b1;
    end else if (addrPhase && sckRise && lastAddrBit) begin
      addrPhase <= 1'b0;
    end
  end
  logic bcastSeen;
  // only the seven address bits count; the direction bit is ignored
  // the match fires on the scl fall after the eighth bit, before the ack
  assign bcastSeen = !addrPhase && (bitCnt == ADDR_BITS) && sclFall
                     && (addrShift[7:1] == I3C_BCAST_ADDR);

  ////////////////////////////////////////////////////////////////////////
  // protocol state machine
  // a csb rise with enough edges beats a broadcast match in one cycle:
  // spi is the stronger claim and no bus event can take it back
  hps_mode_e next_mode;
  always_comb begin
    next_mode = mode;
    case (mode)
      HPS_I2C: begin
        if (csbRise && edgesMet) begin
          next_mode = HPS_SPI;
        end else if (bcastSeen && pins.csbN) begin
          next_mode = HPS_I3C;
        end
      end
      HPS_I3C: begin
        if (csbRise && edgesMet) begin
          next_mode = HPS_SPI;
        end
      end
      default: begin
        next_mode = HPS_SPI;
      end
    endcase
  end

  // reset or soft reset is the only way back; no bus event returns the mode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode <= HPS_I2C;
    end else if (softReset) begin
      mode <= HPS_I2C;
    end else begin
      mode <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // selection flags; engines are slave only, speed grades handled there
  // flags decode next_mode so they move together with mode; a soft reset
  // drops every enable flag for one cycle before the i2c flag comes back; spiCpol keeps its value
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sel <= SEL_RESET;
    end else begin
      sel.i2cEn   <= (next_mode == HPS_I2C) && pins.csbN && !softReset;
      sel.i3cEn   <= (next_mode == HPS_I3C) && pins.csbN && !softReset;
      sel.spiEn   <= (next_mode == HPS_SPI) && !softReset;
      sel.spiCpol <= spiCpol;
    end
  end
endmodule
`default_nettype wire

// ===== dv/hps_select_monitor.sv
// checker for the protocol selector
`default_nettype none
module hps_select_monitor (
  input wire logic               mclk,
  input wire logic               resetn,
  input wire logic               softReset,
  input wire hps_pkg::hps_sel_s  sel,
  input wire hps_pkg::hps_mode_e mode,
  input wire logic               csbActive
);
  timeunit 1ns;
  timeprecision 1ns;
  import hps_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // csb seen low long enough for the registered flags
  sequence s_csbLow;
    csbActive [*3];
  endsequence
  property p_soft; softReset |=> mode == HPS_I2C; endproperty
  property p_csb; s_csbLow |-> !sel.i2cEn && !sel.i3cEn; endproperty
  property p_spiHold; mode == HPS_SPI && !softReset |=> mode == HPS_SPI; endproperty
  property p_i3cHold; mode == HPS_I3C && !softReset |=> mode != HPS_I2C; endproperty
  property p_spiIn; $rose(mode == HPS_SPI) |-> !csbActive ##[0:1] sel.spiEn; endproperty
  property p_i3cIn; $rose(mode == HPS_I3C) |-> $past(mode) == HPS_I2C; endproperty
  property p_excl; !(sel.spiEn && (sel.i2cEn || sel.i3cEn)); endproperty
  property p_i3cSel; sel.i3cEn |-> mode == HPS_I3C || $past(mode) == HPS_I3C; endproperty
  a_soft: assert property (p_soft) else $error("mode not idle after soft reset");
  a_csb: assert property (p_csb) else $error("i2c flags on while csb low");
  a_spiHold: assert property (p_spiHold) else $error("left spi");
  a_i3cHold: assert property (p_i3cHold) else $error("i3c fell back");
  a_spiIn: assert property (p_spiIn) else $error("bad spi entry");
  a_i3cIn: assert property (p_i3cIn) else $error("i3c not from i2c");
  a_excl: assert property (p_excl) else $error("two protocols on");
  a_i3cSel: assert property (p_i3cSel) else $error("i3c flag stray");
endmodule
bind hps_select hps_select_monitor chk (.mclk, .resetn, .softReset, .sel, .mode, .csbActive);
`default_nettype wire

// ===== dv/hps_host.sv
// host controller model on the bus pins
`default_nettype none
module hps_host (
  input  wire logic mclk,
  output logic      csbN,
  output logic      sck,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ns;
  // lines idle high, as their pull-ups leave them
  initial begin
    csbN = 1'b1;
    sck = 1'b1;
    sda = 1'b1;
  end
  // half a link period of 400 ns
  task automatic hp();
    repeat (4) @(posedge mclk);
    #1;
  endtask
  // spi frame, sck still around csb edges; sck is set to c while csb is high, before it falls
  task automatic spi(input int n, input logic c, input logic [31:0] d);
    sck = c;
    hp();
    csbN = 1'b0;
    hp();
    for (int i = 0; i < n; i++) begin
      sda = d[i];
      sck = ~sck;
      hp();
    end
    csbN = 1'b1;
    sda = 1'b1;
    hp();
  endtask
  // start, address byte msb first, ack slot, stop
  task automatic i2c(input logic [7:0] b);
    logic [8:0] f;
    f = {b, 1'b1};
    sck = 1'b1;
    hp();
    sda = 1'b0;
    hp();
    for (int i = 8; i >= 0; i--) begin
      sck = 1'b0;
      sda = f[i];
      hp();
      sck = 1'b1;
      hp();
    end
    // stop: sda rises while scl is high
    sck = 1'b0;
    sda = 1'b0;
    hp();
    sck = 1'b1;
    hp();
    sda = 1'b1;
    hp();
  endtask
endmodule
`default_nettype wire

// ===== dv/test_hps_select.sv
// self-checking bench for the protocol selector
`default_nettype none
module test_hps_select;
  timeunit 1ns;
  timeprecision 1ns;
  import hps_pkg::*;
  logic      mclk, resetn, softReset, csbN, sck, sda, csbActive, c, ec;
  hps_sel_s  sel;
  hps_mode_e mode, em;
  int        miscompares = 0, n_compared = 0, seed = 52, n;
  hps_host host (.mclk, .csbN, .sck, .sda);
  hps_select uut (.mclk, .resetn, .softReset, .csbN, .sck, .sda, .sel, .mode, .csbActive);
  //////////////////////////////////////////////////
  // clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [3:0] s, input logic [3:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic hps_mode_e afSpi(hps_mode_e m, int k);
    return (k >= SPI_EDGE_MIN) ? HPS_SPI : m;
  endfunction
  function automatic hps_mode_e afAdr(hps_mode_e m, logic [7:0] b);
    return (m == HPS_I2C && b[7:1] == I3C_BCAST_ADDR) ? HPS_I3C : m;
  endfunction
  // settle, then compare mode and flags
  task automatic look();
    repeat (6) @(posedge mclk);
    #1;
    chk("mode", {2'h0, mode}, {2'h0, em});
    chk("sel", {1'b0, sel[3:1]}, {1'b0, em == HPS_I2C, em == HPS_I3C, em == HPS_SPI});
    chk("csbActive", {3'h0, csbActive}, 4'h0);
    if (em == HPS_SPI) chk("cpol", {3'h0, sel.spiCpol}, {3'h0, ec});
  endtask
  // spi frame with a look at the flags while csb is still low
  task automatic spiMid(input int k, input logic p);
    fork
      host.spi(k, p, 32'hA5A5A5A5);
      begin
        repeat (10) @(posedge mclk);
        #1;
        chk("csbActive", {3'h0, csbActive}, 4'h1);
        chk("i2cEn", {3'h0, sel.i2cEn}, 4'h0);
        chk("i3cEn", {3'h0, sel.i3cEn}, 4'h0);
      end
    join
    ec = p;
    em = afSpi(em, k);
  endtask
  task automatic end_sim();
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog, over ten times the expected run
  initial begin
    #2000000;
    miscompares++;
    end_sim();
  end
  // corner cases, then random traffic
  initial begin
    resetn = 1'b0;
    softReset = 1'b0;
    em = HPS_I2C;
    repeat (6) @(posedge mclk);
    #1 resetn = 1'b1;
    look();
    spiMid(10, 1'b0);
    spiMid(10, 1'b0);
    look();
    spiMid(15, 1'b1);
    look();
    host.i2c({I3C_BCAST_ADDR, 1'b0});
    em = afAdr(em, {I3C_BCAST_ADDR, 1'b0});
    look();
    spiMid(16, 1'b1);
    look();
    host.i2c({I3C_BCAST_ADDR, 1'b1});
    em = afAdr(em, {I3C_BCAST_ADDR, 1'b1});
    look();
    // power-up again in mid-run
    resetn = 1'b0;
    repeat (2) @(posedge mclk);
    #1 resetn = 1'b1;
    em = HPS_I2C;
    look();
    for (int k = 0; k < 24; k++) begin
      case ($unsigned($random(seed)) % 3)
        0: begin
          n = 14 + $unsigned($random(seed)) % 4;
          c = 1'($random(seed));
          host.spi(n, c, $random(seed));
          ec = c;
          em = afSpi(em, n);
        end
        1: begin
          n = $random(seed);
          if (n[9]) n[7:1] = I3C_BCAST_ADDR;
          host.i2c(n[7:0]);
          em = afAdr(em, n[7:0]);
        end
        default: begin
          softReset = 1'b1;
          @(posedge mclk);
          #1 softReset = 1'b0;
          em = HPS_I2C;
        end
      endcase
      look();
    end
    end_sim();
  end
endmodule
`default_nettype wire
